// >>> design/nbp_defs.svh
`ifndef NBP_DEFS_SVH
`define NBP_DEFS_SVH
// Command codes sent to the flash
`define NBP_CMD_PROG1      8'h80
`define NBP_CMD_PROG2      8'h10
`define NBP_CMD_CACHE2     8'h15
`define NBP_CMD_ERASE1     8'h60
`define NBP_CMD_ERASE2     8'hd0
`define NBP_CMD_STATUS     8'h70
// Geometry
`define NBP_NUM_BLOCKS     4096
`define NBP_MAX_PARTIAL    3'h4
`define NBP_ADDR_CYCLES    3'h5
// Timing, figures in ns, counts in 20 ns cycles
`define NBP_CLK_NS         20
`define NBP_T_PHASE_NS     40
`define NBP_T_PHASE_CYC    ((`NBP_T_PHASE_NS + `NBP_CLK_NS - 1) / `NBP_CLK_NS)
`define NBP_T_ADL_NS       100
`define NBP_T_ADL_CYC      ((`NBP_T_ADL_NS + `NBP_CLK_NS - 1) / `NBP_CLK_NS)
`define NBP_T_WB_NS        100
`define NBP_T_WB_CYC       ((`NBP_T_WB_NS + `NBP_CLK_NS - 1) / `NBP_CLK_NS)
`define NBP_FIFO_DEPTH     8
`endif

// >>> design/nbp_pkg.sv
package nbp_pkg;
	typedef enum logic [1:0] {
		NBP_OP_PROG,
		NBP_OP_CACHE,
		NBP_OP_ERASE
	} nbp_op_t;

	typedef enum {
		NBP_IDLE,
		NBP_CMD1,
		NBP_ADDR,
		NBP_ADL,
		NBP_DATA,
		NBP_CMD2,
		NBP_WBUSY,
		NBP_BUSY,
		NBP_DONE
	} nbp_state_t;
endpackage : nbp_pkg

// >>> design/nbp_fifo.sv
`timescale 1ns/1ns
module nbp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             rst_n,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
	logic [AW:0]      cnt_reg, cnt_next;
	logic             push, pop;

	// Full and empty come from the fill count, so a full buffer never aliases as empty
	assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data  = mem[rd_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Pointer arithmetic wraps at depth
	always_comb begin
		wr_next  = push ? ((wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + AW'(1)) : wr_reg;
		rd_next  = pop ? ((rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + AW'(1)) : rd_reg;
		cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			wr_reg  <= wr_next;
			rd_reg  <= rd_next;
			cnt_reg <= cnt_next;
		end
	end

	// Storage needs no reset
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wr_reg] <= in_data;
		end
	end
endmodule : nbp_fifo

// >>> design/nbp_host.sv
`timescale 1ns/1ns
`include "nbp_defs.svh"
module nbp_host (
	// Clock and reset
	input  wire logic                   mclk,
	input  wire logic                   rst_n,
	// Request port
	input  wire logic                   req_valid,
	output logic                        req_ready,
	input  wire logic [1:0]             req_op,
	input  wire logic [39:0]            req_addr,
	input  wire logic [8:0]             req_len,
	input  wire logic                   wp_enable,
	// Write data stream
	input  wire logic                   wdata_valid,
	output logic                        wdata_ready,
	input  wire logic [7:0]             wdata,
	// Bad block maintenance
	input  wire logic                   mark_bad_valid,
	input  wire logic [11:0]            mark_bad_block,
	// Completion
	output logic                        done_pulse,
	output logic                        err_refused,
	// Flash pins
	output logic                        chip_en_n,
	output logic                        cmd_latch,
	output logic                        addr_latch,
	output logic                        write_strobe_n,
	output logic                        read_strobe_n,
	output logic                        write_prot_n,
	output logic [7:0]                  io_out,
	output logic                        io_oe_n,
	input  wire logic [7:0]             io_in,
	input  wire logic                   ready_busy_n
);
	localparam int PW = 4;
	nbp_pkg::nbp_state_t st_reg, st_next;
	logic [PW-1:0] tm_reg, tm_next;
	logic [2:0]  ac_reg, ac_next;
	logic [8:0]  dc_reg, dc_next;
	logic        ph_reg, ph_next;
	logic [1:0]  op_reg, op_next;
	logic [39:0] ad_reg, ad_next;
	logic [8:0]  ln_reg, ln_next;
	logic        ce_reg, ce_next, cl_reg, cl_next, al_reg, al_next, we_reg, we_next;
	logic        oe_reg, oe_next, dn_reg, dn_next, er_reg, er_next, wp_reg;
	logic [7:0]  io_reg, io_next;
	logic        bad_reg [`NBP_NUM_BLOCKS];
	logic [2:0]  pp_reg [`NBP_NUM_BLOCKS];
	logic        f_valid, f_ready;
	logic [7:0]  f_data;
	logic [11:0] blk;

	// Block index sits in the row bytes of the address
	function automatic logic [11:0] blk_of(input logic [39:0] a);
		return a[33:22];
	endfunction

	// Write data is buffered so a bursty source can run ahead of the pins
	nbp_fifo #(.WIDTH(8), .DEPTH(`NBP_FIFO_DEPTH)) u_fifo (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.in_valid  (wdata_valid),
		.in_ready  (wdata_ready),
		.in_data   (wdata),
		.out_valid (f_valid),
		.out_ready (f_ready),
		.out_data  (f_data)
	);

	assign blk     = blk_of(req_addr);
	assign f_ready = (st_reg == nbp_pkg::NBP_DATA) && !ph_reg && (tm_reg == '0) && f_valid;

	// Sequencer: each pin cycle has a low phase then a high phase of fixed length
	always_comb begin
		st_next = st_reg; tm_next = tm_reg; ac_next = ac_reg; dc_next = dc_reg;
		ph_next = ph_reg; op_next = op_reg; ad_next = ad_reg; ln_next = ln_reg;
		ce_next = ce_reg; cl_next = cl_reg; al_next = al_reg; we_next = we_reg;
		oe_next = oe_reg; io_next = io_reg; dn_next = 1'b0; er_next = 1'b0;
		if (tm_reg != '0) begin
			tm_next = tm_reg - PW'(1);
		end else begin
			unique case (st_reg)
			nbp_pkg::NBP_IDLE: begin
				if (req_valid) begin
					// Refuse bad, worn or protected targets before touching pins
					if (bad_reg[blk] || !wp_enable ||
					    (req_op != 2'(nbp_pkg::NBP_OP_ERASE) &&
					     pp_reg[blk] >= `NBP_MAX_PARTIAL)) begin
						er_next = 1'b1;
					end else begin
						op_next = req_op; ad_next = req_addr; ln_next = req_len;
						ce_next = 1'b0; cl_next = 1'b1; oe_next = 1'b0; we_next = 1'b0;
						io_next = (req_op == 2'(nbp_pkg::NBP_OP_ERASE)) ?
							`NBP_CMD_ERASE1 : `NBP_CMD_PROG1;
						ph_next = 1'b0; tm_next = PW'(`NBP_T_PHASE_CYC);
						st_next = nbp_pkg::NBP_CMD1;
					end
				end
			end
			nbp_pkg::NBP_CMD1, nbp_pkg::NBP_CMD2: begin
				if (!ph_reg) begin
					we_next = 1'b1; ph_next = 1'b1; tm_next = PW'(`NBP_T_PHASE_CYC);
				end else begin
					cl_next = 1'b0; ph_next = 1'b0;
					if (st_reg == nbp_pkg::NBP_CMD2) begin
						oe_next = 1'b1; tm_next = PW'(`NBP_T_WB_CYC);
						st_next = nbp_pkg::NBP_WBUSY;
					end else begin
						// Erase takes only the three row cycles
						ac_next = (op_reg == 2'(nbp_pkg::NBP_OP_ERASE)) ? 3'h2 : 3'h0;
						al_next = 1'b1; we_next = 1'b0;
						io_next = (op_reg == 2'(nbp_pkg::NBP_OP_ERASE)) ? ad_reg[23:16] : ad_reg[7:0];
						tm_next = PW'(`NBP_T_PHASE_CYC); st_next = nbp_pkg::NBP_ADDR;
					end
				end
			end
			nbp_pkg::NBP_ADDR: begin
				if (!ph_reg) begin
					we_next = 1'b1; ph_next = 1'b1; tm_next = PW'(`NBP_T_PHASE_CYC);
				end else if (ac_reg != `NBP_ADDR_CYCLES - 3'h1) begin
					ac_next = ac_reg + 3'h1; we_next = 1'b0; ph_next = 1'b0;
					io_next = ad_reg[8*(ac_reg+3'h1) +: 8];
					tm_next = PW'(`NBP_T_PHASE_CYC);
				end else begin
					al_next = 1'b0; ph_next = 1'b0;
					if (op_reg == 2'(nbp_pkg::NBP_OP_ERASE)) begin
						cl_next = 1'b1; we_next = 1'b0; io_next = `NBP_CMD_ERASE2;
						tm_next = PW'(`NBP_T_PHASE_CYC); st_next = nbp_pkg::NBP_CMD2;
					end else begin
						// Hold off the first data strobe rise after the last address rise
						tm_next = PW'(`NBP_T_ADL_CYC);
						dc_next = '0; st_next = nbp_pkg::NBP_ADL;
					end
				end
			end
			nbp_pkg::NBP_ADL: begin
				st_next = nbp_pkg::NBP_DATA;
			end
			nbp_pkg::NBP_DATA: begin
				if (!ph_reg) begin
					// Stall with strobe high while the buffer is empty
					if (f_valid) begin
						we_next = 1'b0; io_next = f_data; ph_next = 1'b1;
						tm_next = PW'(`NBP_T_PHASE_CYC);
					end
				end else if (!we_reg) begin
					we_next = 1'b1; tm_next = PW'(`NBP_T_PHASE_CYC);
				end else begin
					ph_next = 1'b0; dc_next = dc_reg + 9'h1;
					if (dc_reg + 9'h1 == ln_reg) begin
						cl_next = 1'b1; we_next = 1'b0;
						io_next = (op_reg == 2'(nbp_pkg::NBP_OP_CACHE)) ?
							`NBP_CMD_CACHE2 : `NBP_CMD_PROG2;
						tm_next = PW'(`NBP_T_PHASE_CYC); st_next = nbp_pkg::NBP_CMD2;
					end
				end
			end
			nbp_pkg::NBP_WBUSY: begin
				st_next = nbp_pkg::NBP_BUSY;
			end
			nbp_pkg::NBP_BUSY: begin
				// Wait out the device busy time, cache dummy busy included
				if (ready_busy_n) begin
					ce_next = 1'b1; st_next = nbp_pkg::NBP_DONE;
				end
			end
			nbp_pkg::NBP_DONE: begin
				dn_next = 1'b1; st_next = nbp_pkg::NBP_IDLE;
			end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= nbp_pkg::NBP_IDLE; tm_reg <= '0; ac_reg <= '0; dc_reg <= '0;
			ph_reg <= 1'b0; op_reg <= '0; ad_reg <= '0; ln_reg <= '0;
			ce_reg <= 1'b1; cl_reg <= 1'b0; al_reg <= 1'b0; we_reg <= 1'b1;
			oe_reg <= 1'b1; io_reg <= '0; dn_reg <= 1'b0; er_reg <= 1'b0;
			wp_reg <= 1'b0;
		end else begin
			st_reg <= st_next; tm_reg <= tm_next; ac_reg <= ac_next; dc_reg <= dc_next;
			ph_reg <= ph_next; op_reg <= op_next; ad_reg <= ad_next; ln_reg <= ln_next;
			ce_reg <= ce_next; cl_reg <= cl_next; al_reg <= al_next; we_reg <= we_next;
			oe_reg <= oe_next; io_reg <= io_next; dn_reg <= dn_next; er_reg <= er_next;
			wp_reg <= wp_enable;
		end
	end

	// Bad block table and partial program counts; cleared on reset so no count starts
	// unknown and silently stops refusing. Limitation: the owner must re-mark factory
	// bad blocks after every reset.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `NBP_NUM_BLOCKS; i++) begin
				bad_reg[i] <= 1'b0;
				pp_reg[i]  <= 3'h0;
			end
		end else begin
			if (mark_bad_valid) begin
				bad_reg[mark_bad_block] <= 1'b1;
			end
			if (st_reg == nbp_pkg::NBP_IDLE && tm_reg == '0 && req_valid &&
			    st_next != st_reg) begin
				pp_reg[blk] <= (req_op == 2'(nbp_pkg::NBP_OP_ERASE)) ?
					3'h0 : pp_reg[blk] + 3'h1;
			end
		end
	end

	// Pin and handshake outputs straight from flip-flops, except req_ready from state and timer, wdata_ready from the fill count, and read strobe tied high
	assign req_ready      = (st_reg == nbp_pkg::NBP_IDLE) && (tm_reg == '0);
	assign done_pulse     = dn_reg;
	assign err_refused    = er_reg;
	assign chip_en_n      = ce_reg;
	assign cmd_latch      = cl_reg;
	assign addr_latch     = al_reg;
	assign write_strobe_n = we_reg;
	assign read_strobe_n  = 1'b1;
	assign write_prot_n   = wp_reg;
	assign io_out         = io_reg;
	assign io_oe_n        = oe_reg;
endmodule : nbp_host

// >>> tb/nbp_host_assertions.sv
`timescale 1ns/1ns
`include "nbp_defs.svh"
module nbp_host_assertions (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        rst_n,
	// Requests and outcome
	input wire logic        req_valid,
	input wire logic        req_ready,
	input wire logic [39:0] req_addr,
	input wire logic        wp_enable,
	input wire logic        mark_bad_valid,
	input wire logic [11:0] mark_bad_block,
	input wire logic        done_pulse,
	input wire logic        err_refused,
	// Flash pins
	input wire logic        chip_en_n,
	input wire logic        cmd_latch,
	input wire logic        addr_latch,
	input wire logic        write_strobe_n,
	input wire logic        write_prot_n,
	input wire logic [7:0]  io_out,
	input wire logic        io_oe_n,
	input wire logic        ready_busy_n
);
	logic [4095:0] bad_reg, bad_next;
	logic [2:0]    acnt_reg, acnt_next;
	logic [3:0]    gap_reg, gap_next;
	logic          wsn_reg, wsn_next, alat_reg, alat_next;
	wire           stb = !write_strobe_n && wsn_reg;
	wire           rise = write_strobe_n && !wsn_reg;
	// Shadow of retired blocks, address count and gap since the last address strobe
	always_comb begin
		bad_next = bad_reg;
		if (mark_bad_valid)
			bad_next[mark_bad_block] = 1'b1;
		acnt_next = acnt_reg;
		if (stb && cmd_latch)
			acnt_next = 3'h0;
		else if (stb && addr_latch)
			acnt_next = acnt_reg + 3'h1;
		gap_next = (gap_reg == 4'hf) ? gap_reg : gap_reg + 4'h1;
		if (rise && addr_latch)
			gap_next = 4'h0;
		wsn_next = write_strobe_n;
		alat_next = rise ? addr_latch : alat_reg;
	end
	// Shadow table clears on reset, as the host's own table does
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bad_reg <= '0;
			acnt_reg <= 3'h0;
			gap_reg <= 4'hf;
			wsn_reg <= 1'b1;
			alat_reg <= 1'b0;
		end else begin
			bad_reg <= bad_next;
			acnt_reg <= acnt_next;
			gap_reg <= gap_next;
			wsn_reg <= wsn_next;
			alat_reg <= alat_next;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence taken_s; req_valid && req_ready; endsequence
	sequence refuse_s; ##1 err_refused ##1 !err_refused; endsequence
	wp_refuse_a: assert property (taken_s ##0 !wp_enable |-> refuse_s)
		else $error("protected request not refused");
	bad_refuse_a: assert property (taken_s ##0 bad_reg[req_addr[33:22]] |-> refuse_s)
		else $error("retired block not refused");
	refuse_cause_a: assert property (err_refused |-> $past(req_valid && req_ready))
		else $error("refusal without request");
	latch_excl_a: assert property (!(cmd_latch && addr_latch))
		else $error("both latches high");
	cmd_drive_a: assert property (stb && cmd_latch |-> !chip_en_n && !io_oe_n)
		else $error("command strobe without drive");
	prog_addr_a: assert property (stb && cmd_latch && (io_out == `NBP_CMD_PROG2 ||
		io_out == `NBP_CMD_CACHE2) |-> acnt_reg == `NBP_ADDR_CYCLES)
		else $error("program address count wrong");
	erase_addr_a: assert property (stb && cmd_latch && io_out == `NBP_CMD_ERASE2
		|-> acnt_reg == 3'h3)
		else $error("erase address count wrong");
	adl_gap_a: assert property (rise && !cmd_latch && !addr_latch && alat_reg
		|-> gap_reg >= 4'h4)
		else $error("address to data gap short");
	done_ready_a: assert property (done_pulse |-> $past(ready_busy_n))
		else $error("done while flash busy");
	prot_follow_a: assert property ($past(rst_n) |-> write_prot_n == $past(wp_enable))
		else $error("protect pin not following enable");
endmodule : nbp_host_assertions
bind nbp_host nbp_host_assertions u_chk (.mclk, .rst_n, .req_valid, .req_ready, .req_addr,
	.wp_enable, .mark_bad_valid, .mark_bad_block, .done_pulse, .err_refused, .chip_en_n,
	.cmd_latch, .addr_latch, .write_strobe_n, .write_prot_n, .io_out, .io_oe_n, .ready_busy_n);

// >>> tb/nbp_flash_model.sv
`timescale 1ns/1ns
`include "nbp_defs.svh"
module nbp_flash_model #(
	parameter int BUSY_NS  = 6000,
	parameter int CBUSY_NS = 3000
) (
	// Host pins
	input wire logic       chip_en_n,
	input wire logic       cmd_latch,
	input wire logic       addr_latch,
	input wire logic       write_strobe_n,
	input wire logic       write_prot_n,
	input wire logic [7:0] io_out,
	// Flash outputs
	output logic [7:0]     io_in,
	output logic           ready_busy_n
);
	logic [7:0]  cmd1, cmd2, data_q[$];
	logic [39:0] addr_sh;
	logic        last_addr;
	int          adl_err;
	time         t_addr;
	// Never drives reads, so the bus shows the inverse of the host's value
	assign io_in = ~io_out;
	// Starts ready, with no gap errors counted and no address cycle last
	initial begin
		ready_busy_n = 1'b1;
		adl_err = 0;
		last_addr = 1'b0;
	end
	// Latch on strobe rise; deselected, protected or busy writes are ignored
	always @(posedge write_strobe_n) begin
		if (!chip_en_n && write_prot_n && ready_busy_n) begin
			if (cmd_latch && (io_out == `NBP_CMD_PROG1 || io_out == `NBP_CMD_ERASE1)) begin
				cmd1 = io_out;
				data_q.delete();
			end else if (cmd_latch) begin
				cmd2 = io_out;
				#(`NBP_T_WB_NS / 2) ready_busy_n = 1'b0;
				#(io_out == `NBP_CMD_CACHE2 ? CBUSY_NS : BUSY_NS) ready_busy_n = 1'b1;
			end else if (addr_latch) begin
				addr_sh = {io_out, addr_sh[39:8]};
				t_addr = $time;
			end else begin
				if (last_addr && $time - t_addr < `NBP_T_ADL_NS)
					adl_err++;
				data_q.push_back(io_out);
			end
			last_addr = addr_latch;
		end
	end
endmodule : nbp_flash_model

// >>> tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	logic        mclk, rst_n, req_valid, wp_enable, wdata_valid, mark_bad_valid;
	logic [1:0]  req_op;
	logic [39:0] req_addr;
	logic [8:0]  req_len;
	logic [7:0]  wdata, io_out, io_in;
	logic [11:0] mark_bad_block;
	logic        req_ready, wdata_ready, done_pulse, err_refused, chip_en_n, cmd_latch;
	logic        addr_latch, write_strobe_n, read_strobe_n, write_prot_n, io_oe_n, ready_busy_n;
	int          n_fail, check_count;
	nbp_host DUT (.mclk, .rst_n, .req_valid, .req_ready, .req_op, .req_addr, .req_len,
		.wp_enable, .wdata_valid, .wdata_ready, .wdata, .mark_bad_valid, .mark_bad_block,
		.done_pulse, .err_refused, .chip_en_n, .cmd_latch, .addr_latch, .write_strobe_n,
		.read_strobe_n, .write_prot_n, .io_out, .io_oe_n, .io_in, .ready_busy_n);
	nbp_flash_model FM (.chip_en_n, .cmd_latch, .addr_latch, .write_strobe_n,
		.write_prot_n, .io_out, .io_in, .ready_busy_n);
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize
	// Inputs change on falling edges so the host samples settled values
	task automatic push(input int n, input logic [7:0] base);
		for (int i = 0; i < n; i++) begin
			@(negedge mclk);
			wdata_valid = 1'b1;
			wdata = base + 8'(i);
			while (wdata_ready !== 1'b1) @(negedge mclk);
		end
		@(negedge mclk);
		wdata_valid = 1'b0;
	endtask : push
	task automatic mark(input logic [11:0] blk);
		@(negedge mclk);
		mark_bad_valid = 1'b1;
		mark_bad_block = blk;
		@(negedge mclk);
		mark_bad_valid = 1'b0;
	endtask : mark
	task automatic do_op(input logic [1:0] op, input logic [11:0] blk, input logic [8:0] len,
		input logic refuse);
		@(negedge mclk);
		req_op = op;
		req_addr = {6'h00, blk, 22'h000000};
		req_len = len;
		req_valid = 1'b1;
		while (req_ready !== 1'b1) @(negedge mclk);
		@(negedge mclk);
		req_valid = 1'b0;
		for (int k = 0; k < 2000 && done_pulse !== 1'b1 && err_refused !== 1'b1; k++)
			@(negedge mclk);
		check("refused", refuse, err_refused);
		check("done", !refuse, done_pulse);
		check("idle pins", 3'b111, {chip_en_n, io_oe_n, read_strobe_n});
	endtask : do_op
	// Buffer fills to its depth and refuses, then one program drains it in order
	task automatic scn_fill_program();
		push(8, 8'ha0);
		check("wdata_ready", 1'b0, wdata_ready);
		do_op(2'h0, 12'h001, 9'h008, 1'b0);
		for (int i = 0; i < 8; i++)
			check("data", 8'ha0 + 8'(i), FM.data_q[i]);
		check("cmd", {8'h80, 8'h10}, {FM.cmd1, FM.cmd2});
		check("row", {6'h00, 12'h001, 6'h00}, FM.addr_sh[39:16]);
	endtask : scn_fill_program
	// Cache confirm waits out the dummy busy; the address to data gap is kept
	task automatic scn_cache();
		push(2, 8'h55);
		do_op(2'h1, 12'h001, 9'h002, 1'b0);
		check("cache", 8'h15, FM.cmd2);
		check("data", 8'h56, FM.data_q[1]);
		check("adl", 0, FM.adl_err);
	endtask : scn_cache
	// Erase sends the command pair and only the row bytes
	task automatic scn_erase();
		do_op(2'h2, 12'h003, 9'h000, 1'b0);
		check("erase", {8'h60, 8'hd0}, {FM.cmd1, FM.cmd2});
		check("row", {6'h00, 12'h003, 6'h00}, FM.addr_sh[39:16]);
	endtask : scn_erase
	// Fifth partial program is refused until the block is erased
	task automatic scn_partial();
		push(5, 8'h30);
		for (int i = 0; i < 4; i++) begin
			do_op(2'h0, 12'h004, 9'h001, 1'b0);
			check("partial data", 8'h30 + 8'(i), FM.data_q[0]);
		end
		do_op(2'h0, 12'h004, 9'h001, 1'b1);
		do_op(2'h2, 12'h004, 9'h000, 1'b0);
		do_op(2'h0, 12'h004, 9'h001, 1'b0);
		check("partial data", 8'h34, FM.data_q[0]);
	endtask : scn_partial
	// Factory bad and later retired blocks are both refused
	task automatic scn_bad();
		do_op(2'h0, 12'h007, 9'h001, 1'b1);
		do_op(2'h2, 12'h007, 9'h000, 1'b1);
		mark(12'h001);
		do_op(2'h2, 12'h001, 9'h000, 1'b1);
	endtask : scn_bad
	// Protect pin follows the enable and writes are refused while it is low
	task automatic scn_protect();
		@(negedge mclk);
		wp_enable = 1'b0;
		@(negedge mclk);
		check("write_prot_n", 1'b0, write_prot_n);
		do_op(2'h2, 12'h003, 9'h000, 1'b1);
	endtask : scn_protect
	initial begin
		{req_valid, wdata_valid, mark_bad_valid, req_op, req_addr, req_len, wdata} = '0;
		mark_bad_block = 12'h000;
		wp_enable = 1'b1;
		rst_n = 1'b0;
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		rst_n = 1'b1;
		// Factory bad block is marked before any request reaches it
		mark(12'h007);
		scn_fill_program();
		scn_cache();
		scn_erase();
		scn_partial();
		scn_bad();
		scn_protect();
		summarize();
	end
	// Whole run needs well under a millisecond
	initial begin
		#1000000;
		n_fail++;
		$display("[ERR] watchdog expected finish seen timeout");
		summarize();
	end
endmodule : tb_top
